//--- hdl/slls_pkg.sv
// Constants, field layout and register map of the lane link status block
//
// Function
// (R01) Lane1 bit7: disparity count at/above threshold
// (R02) Lane1 bit6: not-in-table count at/above threshold
// (R03) Lane1 bit5: unexpected control count at/above threshold
// (R04) Lane1 bit4: inter-lane deskew achieved
// (R05) Lane1 bit3: initial lane alignment achieved
// (R06) Lane1 bit2: configuration checksum matched
// (R07) Lane1 bit1: frame alignment achieved
// (R08) Lane1 bit0: code-group alignment achieved
// (R09) Lane0 bits 2..0 same encodings
// (R10) Reads show only the page-selected link
// (R11) Flags reset to zero, writes ignored
// (R12) Lane0 bits 7..3 same as lane1
// (R13) 8-bit counters, terminal 0xFF, hold or wrap
// (R14) Flags follow live state, never latched
package slls_pkg;

  // Structure
  localparam int NUM_LINKS = 2;
  localparam int NUM_LANES = 2;
  localparam int NUM_ERR   = 3;
  localparam int NUM_LIVE  = 5;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] PAGE_ADDR       = 12'h300;
  localparam logic [ADDR_W-1:0] LANE0_STAT_ADDR = 12'h4B0;
  localparam logic [ADDR_W-1:0] LANE1_STAT_ADDR = 12'h4B1;
  localparam logic [ADDR_W-1:0] THRESH_ADDR     = 12'h4C0;
  localparam logic [ADDR_W-1:0] CNT_CTRL_ADDR   = 12'h4C1;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR   = 12'h4C2;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 12'h4C3;
  localparam logic [ADDR_W-1:0] TERM_ADDR       = 12'h4C4;

  // Status byte fields
  localparam int BIT_DISP   = 7;
  localparam int BIT_NIT    = 6;
  localparam int BIT_UEK    = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_ILAS   = 3;
  localparam int BIT_CKS    = 2;
  localparam int BIT_FS     = 1;
  localparam int BIT_CGS    = 0;

  // Error counter index, also terminal-count bit order
  localparam int ERR_DISP = 0;
  localparam int ERR_NIT  = 1;
  localparam int ERR_UEK  = 2;

  // Counter control and page fields
  localparam int CTRL_HOLD  = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int PAGE_BIT   = 0;

  // Interrupt status fields
  localparam int IRQ_ERR_L0  = 0;
  localparam int IRQ_ERR_L1  = 1;
  localparam int IRQ_LOSS_L0 = 2;
  localparam int IRQ_LOSS_L1 = 3;
  localparam int IRQ_W       = 4;

  // Values
  localparam logic [7:0] CNT_TERMINAL = 8'hFF;
  localparam logic [7:0] STAT_RST     = 8'h00;
  localparam logic [7:0] THRESH_RST   = 8'hFF;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

endpackage : slls_pkg

//--- hdl/slls_lane_if.sv
// Carrier for one lane's status byte and terminal-count flags
interface slls_lane_if;
  logic [7:0] status;
  logic [2:0] term;
  modport src (output status, output term);
  modport snk (input status, input term);
endinterface : slls_lane_if

//--- hdl/slls_lane_stat.sv
// Error counters and status byte of one lane of one link
module slls_lane_stat
  import slls_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                srst_i,
  // Receiver events and live state
  input  wire logic [NUM_ERR-1:0]  err_evt_i,
  input  wire logic [NUM_LIVE-1:0] live_i,
  // Controls
  input  wire logic [7:0]          thresh_i,
  input  wire logic                hold_i,
  input  wire logic                clr_i,
  // Status out
  slls_lane_if.src                 lane
);

  logic [NUM_ERR-1:0][7:0] cnt;
  logic [NUM_ERR-1:0][7:0] next_cnt;
  logic [7:0]              status;
  logic [7:0]              next_status;

  genvar g;
  generate
    for (g = 0; g < NUM_ERR; g++) begin : g_cnt
      // Count events; hold at terminal only when asked, else roll over
      always_comb begin
        next_cnt[g] = cnt[g];
        if (clr_i) begin
          next_cnt[g] = ZERO_BYTE;
        end else if (err_evt_i[g]) begin
          if (hold_i && cnt[g] == CNT_TERMINAL) begin
            next_cnt[g] = CNT_TERMINAL; // [R13]
          end else begin
            next_cnt[g] = cnt[g] + 8'h01; // [R13]
          end
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          cnt[g] <= ZERO_BYTE;
        end else begin
          cnt[g] <= next_cnt[g];
        end
      end
    end
  endgenerate

  // Status rebuilt every cycle from counters and live levels, no latching
  always_comb begin
    next_status             = STAT_RST;
    next_status[BIT_DISP]   = cnt[ERR_DISP] >= thresh_i; // [R01] [R12]
    next_status[BIT_NIT]    = cnt[ERR_NIT] >= thresh_i;  // [R02] [R12]
    next_status[BIT_UEK]    = cnt[ERR_UEK] >= thresh_i;  // [R03] [R12]
    next_status[BIT_DESKEW] = live_i[BIT_DESKEW];        // [R04] [R12]
    next_status[BIT_ILAS]   = live_i[BIT_ILAS];          // [R05] [R12]
    next_status[BIT_CKS]    = live_i[BIT_CKS];           // [R06] [R09]
    next_status[BIT_FS]     = live_i[BIT_FS];            // [R07] [R09]
    next_status[BIT_CGS]    = live_i[BIT_CGS];           // [R08] [R09] [R14]
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      status <= STAT_RST; // [R11]
    end else begin
      status <= next_status;
    end
  end

  assign lane.status          = status;
  assign lane.term[ERR_DISP]  = cnt[ERR_DISP] == CNT_TERMINAL;
  assign lane.term[ERR_NIT]   = cnt[ERR_NIT] == CNT_TERMINAL;
  assign lane.term[ERR_UEK]   = cnt[ERR_UEK] == CNT_TERMINAL;

endmodule // slls_lane_stat

//--- hdl/slls_top.sv
// Paged lane link status registers with counters and interrupt
module slls_top
  import slls_pkg::*;
(
  // Clock and reset
  input  wire logic                                      ref_clk_i,
  input  wire logic                                      srst_i,
  // Register port
  input  wire logic [ADDR_W-1:0]                         addr_i,
  input  wire logic [DATA_W-1:0]                         wr_data_i,
  input  wire logic                                      wr_en_i,
  input  wire logic                                      rd_en_i,
  output logic      [DATA_W-1:0]                         rd_data_o,
  // Receiver events, per link and lane
  input  wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_ERR-1:0]  err_evt_i,
  input  wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_LIVE-1:0] live_i,
  // Interrupt
  output logic                                           irq_o
);

  // Gathered lane results
  logic [NUM_LINKS-1:0][NUM_LANES-1:0][7:0] lane_status;
  logic [NUM_LINKS-1:0][NUM_LANES-1:0][2:0] lane_term;
  logic [NUM_LINKS-1:0][NUM_LANES-1:0][7:0] prev_status;

  // Software state
  logic             page;
  logic             next_page;
  logic [7:0]       thresh;
  logic [7:0]       next_thresh;
  logic             hold;
  logic             next_hold;
  logic             clr;
  logic             next_clr;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic             next_irq;
  logic [7:0]       next_rd_data;

  slls_lane_if lane_if [NUM_LINKS*NUM_LANES] ();

  // Any of the three threshold flags of a status byte
  function automatic logic any_err(input logic [7:0] s);
    any_err = s[BIT_DISP] | s[BIT_NIT] | s[BIT_UEK];
  endfunction

  genvar gk;
  genvar gl;
  generate
    for (gk = 0; gk < NUM_LINKS; gk++) begin : g_link
      for (gl = 0; gl < NUM_LANES; gl++) begin : g_lane
        slls_lane_stat u_lane (
          .ref_clk_i (ref_clk_i),
          .srst_i    (srst_i),
          .err_evt_i (err_evt_i[gk][gl]),
          .live_i    (live_i[gk][gl]),
          .thresh_i  (thresh),
          .hold_i    (hold),
          .clr_i     (clr),
          .lane      (lane_if[gk*NUM_LANES+gl])
        );
        assign lane_status[gk][gl] = lane_if[gk*NUM_LANES+gl].status;
        assign lane_term[gk][gl]   = lane_if[gk*NUM_LANES+gl].term;
      end
    end
  endgenerate

  // Events: threshold flags going from none set to any set, or code-group alignment lost, on any link
  always_comb begin
    irq_evt = '0;
    for (int k = 0; k < NUM_LINKS; k++) begin
      for (int l = 0; l < NUM_LANES; l++) begin
        irq_evt[IRQ_ERR_L0 + l]  = irq_evt[IRQ_ERR_L0 + l]
                                 | (any_err(lane_status[k][l]) & ~any_err(prev_status[k][l]));
        irq_evt[IRQ_LOSS_L0 + l] = irq_evt[IRQ_LOSS_L0 + l]
                                 | (prev_status[k][l][BIT_CGS] & ~lane_status[k][l][BIT_CGS]);
      end
    end
  end

  // Register writes; status bytes and terminal flags ignore writes
  always_comb begin
    next_page     = page;
    next_thresh   = thresh;
    next_hold     = hold;
    next_clr      = 1'h0; // Clear is a one-cycle pulse to the counters
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_en_i) begin
      case (addr_i)
        PAGE_ADDR: begin
          next_page = wr_data_i[PAGE_BIT]; // [R10]
        end
        THRESH_ADDR: begin
          next_thresh = wr_data_i;
        end
        CNT_CTRL_ADDR: begin
          next_hold = wr_data_i[CTRL_HOLD];  // [R13]
          next_clr  = wr_data_i[CTRL_CLEAR]; // [R13]
        end
        IRQ_STAT_ADDR: begin
          next_irq_stat = irq_stat & ~wr_data_i[IRQ_W-1:0];
        end
        IRQ_MASK_ADDR: begin
          next_irq_mask = wr_data_i[IRQ_W-1:0];
        end
        default: begin
          next_page = page; // Read-only or unmapped: no effect [R11]
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | irq_evt;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  // Read data, one cycle after the strobe; only the paged link shows
  always_comb begin
    next_rd_data = ZERO_BYTE;
    if (rd_en_i) begin
      case (addr_i)
        PAGE_ADDR: begin
          next_rd_data[PAGE_BIT] = page;
        end
        LANE0_STAT_ADDR: begin
          next_rd_data = lane_status[page][0]; // [R10] [R09] [R12] [R14]
        end
        LANE1_STAT_ADDR: begin
          next_rd_data = lane_status[page][1]; // [R10] [R14]
        end
        THRESH_ADDR: begin
          next_rd_data = thresh;
        end
        CNT_CTRL_ADDR: begin
          next_rd_data[CTRL_HOLD] = hold;
        end
        IRQ_STAT_ADDR: begin
          next_rd_data[IRQ_W-1:0] = irq_stat;
        end
        IRQ_MASK_ADDR: begin
          next_rd_data[IRQ_W-1:0] = irq_mask;
        end
        TERM_ADDR: begin
          next_rd_data[5:0] = {lane_term[page][1], lane_term[page][0]}; // [R13]
        end
        default: begin
          next_rd_data = ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      page        <= 1'h0;
      thresh      <= THRESH_RST;
      hold        <= 1'h0;
      clr         <= 1'h0;
      irq_stat    <= '0;
      irq_mask    <= '0;
      irq_o       <= 1'h0;
      rd_data_o   <= ZERO_BYTE;
      prev_status <= '0; // Matches lane reset, so no event at release [R11]
    end else begin
      page        <= next_page;
      thresh      <= next_thresh;
      hold        <= next_hold;
      clr         <= next_clr;
      irq_stat    <= next_irq_stat;
      irq_mask    <= next_irq_mask;
      irq_o       <= next_irq;
      rd_data_o   <= next_rd_data;
      prev_status <= lane_status;
    end
  end

endmodule // slls_top

//--- testbench/slls_rx_model.sv
// Receiver-side model driving lane error events and live levels
module slls_rx_model
  import slls_pkg::*;
(
  // Clock
  input  wire logic ref_clk_i,
  // Receiver state toward the block
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_ERR-1:0]  err_evt_o,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_LIVE-1:0] live_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet receiver until told otherwise
  initial begin
    err_evt_o = '0;
    live_o = '0;
  end
  // Live level change, launched just after an edge
  task automatic set_live(input int lk, input int ln, input logic [4:0] v);
    @(posedge ref_clk_i);
    live_o[lk][ln] <= v;
  endtask
  // Back-to-back events, then settle time for counter and status stages
  task automatic burst(input int lk, input int ln, input int ty, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      err_evt_o[lk][ln][ty] <= 1'h1;
    end
    @(posedge ref_clk_i);
    err_evt_o[lk][ln][ty] <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule : slls_rx_model

//--- testbench/slls_checker.sv
// Port-level assertions for the lane link status block
module slls_checker
  import slls_pkg::*;
(
  input wire logic                                              ref_clk_i,
  input wire logic                                              srst_i,
  input wire logic [ADDR_W-1:0]                                 addr_i,
  input wire logic [DATA_W-1:0]                                 wr_data_i,
  input wire logic                                              wr_en_i,
  input wire logic                                              rd_en_i,
  input wire logic [DATA_W-1:0]                                 rd_data_o,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_ERR-1:0]  err_evt_i,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_LIVE-1:0] live_i,
  input wire logic                                              irq_o
);
  logic       pg;
  logic [3:0] msk;
  logic [7:0] thr;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Shadow of the page, mask and threshold controls, so their reads can be judged
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pg <= 1'h0;
      msk <= 4'h0;
      thr <= 8'hFF;
    end else if (wr_en_i) begin
      if (addr_i == PAGE_ADDR) pg <= wr_data_i[0];
      if (addr_i == IRQ_MASK_ADDR) msk <= wr_data_i[3:0];
      if (addr_i == THRESH_ADDR) thr <= wr_data_i;
    end
  end
  a_rd_idle_zero: assert property (!rd_en_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (rd_en_i && addr_i == 12'h000 |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_rst_quiet: assert property ($fell(srst_i) |-> rd_data_o == 8'h00 && !irq_o)
    else $error("outputs not quiet after reset");
  a_lane1_live: assert property (rd_en_i && addr_i == LANE1_STAT_ADDR && !$past(srst_i)
    |=> rd_data_o[4:0] == $past(live_i[pg][1], 2)) else $error("lane1 live bits wrong");
  a_lane0_live: assert property (rd_en_i && addr_i == LANE0_STAT_ADDR && !$past(srst_i)
    |=> rd_data_o[4:0] == $past(live_i[pg][0], 2)) else $error("lane0 live bits wrong");
  a_page_read: assert property (rd_en_i && addr_i == PAGE_ADDR
    |=> rd_data_o == {7'h00, $past(pg)}) else $error("page readback wrong");
  a_thr_read: assert property (rd_en_i && addr_i == THRESH_ADDR |=> rd_data_o == $past(thr))
    else $error("threshold readback wrong");
  a_mask_read: assert property (rd_en_i && addr_i == IRQ_MASK_ADDR
    |=> rd_data_o[3:0] == $past(msk)) else $error("mask readback wrong");
  a_irq_masked: assert property (msk == 4'h0 && $past(msk) == 4'h0 |-> !irq_o)
    else $error("interrupt while fully masked");
endmodule : slls_checker

bind slls_top slls_checker chk_u (.*);

//--- testbench/serdes_lane_link_status_bench.sv
// Self-checking bench for the lane link status block
module serdes_lane_link_status_bench import slls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic              ref_clk_i;
  logic              srst_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i;
  logic              wr_en_i;
  logic              rd_en_i;
  logic [DATA_W-1:0] rd_data_o;
  logic              irq_o;
  logic [7:0]        got;
  int                err_count;
  int                checked;
  int                cycles;
  logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_ERR-1:0]  err_evt;
  logic [NUM_LINKS-1:0][NUM_LANES-1:0][NUM_LIVE-1:0] live;
  slls_top dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .err_evt_i(err_evt), .live_i(live), .irq_o(irq_o));
  slls_rx_model rx_u (.ref_clk_i(ref_clk_i), .err_evt_o(err_evt), .live_o(live));
  initial begin
    ref_clk_i = 1'h0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard, well above the expected run length
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_en_i <= 1'h1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_en_i <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_i);
    rd_en_i <= 1'h1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_en_i <= 1'h0;
    #1 got = rd_data_o;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic t_reset();
    rd(LANE1_STAT_ADDR);
    chk("lane1", got, STAT_RST);
    rd(LANE0_STAT_ADDR);
    chk("lane0", got, STAT_RST);
    rd(THRESH_ADDR);
    chk("thresh", got, THRESH_RST);
    rd(12'h000);
    chk("unmapped", got, ZERO_BYTE);
  endtask
  task automatic t_live();
    rx_u.set_live(0, 1, 5'h15);
    rx_u.set_live(0, 0, 5'h0A);
    rx_u.set_live(1, 1, 5'h0E);
    rd(LANE1_STAT_ADDR);
    chk("lane1 live", got, 8'h15);
    rd(LANE0_STAT_ADDR);
    chk("lane0 live", got, 8'h0A);
    wr(PAGE_ADDR, 8'h01);
    rd(PAGE_ADDR);
    chk("page", got, 8'h01);
    rd(LANE1_STAT_ADDR);
    chk("link1 lane1", got, 8'h0E);
    wr(LANE1_STAT_ADDR, 8'hFF);
    rd(LANE1_STAT_ADDR);
    chk("ro write", got, 8'h0E);
    wr(PAGE_ADDR, 8'h00);
  endtask
  task automatic t_thresh();
    wr(THRESH_ADDR, 8'h03);
    rx_u.burst(0, 1, ERR_DISP, 2);
    rd(LANE1_STAT_ADDR);
    chk("below thr", got, 8'h15);
    rx_u.burst(0, 1, ERR_DISP, 1);
    rd(LANE1_STAT_ADDR);
    chk("disp flag", got, 8'h95);
    rx_u.burst(0, 1, ERR_NIT, 3);
    rd(LANE1_STAT_ADDR);
    chk("nit flag", got, 8'hD5);
    rx_u.burst(0, 1, ERR_UEK, 3);
    rd(LANE1_STAT_ADDR);
    chk("uek flag", got, 8'hF5);
    rx_u.burst(0, 0, ERR_DISP, 3);
    rd(LANE0_STAT_ADDR);
    chk("lane0 disp", got, 8'h8A);
  endtask
  // Masked-out events must not reach the pin; W1C clears one bit only
  task automatic t_irq();
    rd(IRQ_STAT_ADDR);
    chk("irq stat", got, 8'h03);
    chk("irq idle", {7'h00, irq_o}, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h02);
    rd(IRQ_MASK_ADDR);
    chk("mask", got, 8'h02);
    chk("irq on", {7'h00, irq_o}, 8'h01);
    wr(IRQ_STAT_ADDR, 8'h02);
    rx_u.set_live(0, 1, 5'h14);
    rd(LANE1_STAT_ADDR);
    chk("cgs lost", got, 8'hF4);
    rd(IRQ_STAT_ADDR);
    chk("irq w1c", got, 8'h09);
    chk("irq off", {7'h00, irq_o}, 8'h00);
  endtask
  task automatic t_count();
    wr(CNT_CTRL_ADDR, 8'h02);
    repeat (3) @(posedge ref_clk_i);
    rd(LANE1_STAT_ADDR);
    chk("cleared", got, 8'h14);
    wr(THRESH_ADDR, 8'hFF);
    wr(CNT_CTRL_ADDR, 8'h01);
    rd(CNT_CTRL_ADDR);
    chk("hold", got, 8'h01);
    rx_u.burst(0, 1, ERR_DISP, 256);
    rd(TERM_ADDR);
    chk("terminal", got, 8'h08);
    rd(LANE1_STAT_ADDR);
    chk("held", got, 8'h94);
    wr(CNT_CTRL_ADDR, 8'h02);
    repeat (3) @(posedge ref_clk_i);
    rx_u.burst(0, 1, ERR_DISP, 256);
    rd(LANE1_STAT_ADDR);
    chk("wrapped", got, 8'h14);
  endtask
  // Reset in mid-run with a flag and the interrupt up; live levels come back
  task automatic t_midreset();
    wr(THRESH_ADDR, 8'h01);
    rx_u.burst(0, 1, ERR_DISP, 1);
    rd(LANE1_STAT_ADDR);
    chk("flag before rst", got, 8'h94);
    chk("irq before rst", {7'h00, irq_o}, 8'h01);
    @(posedge ref_clk_i);
    srst_i <= 1'h1;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    rd(LANE1_STAT_ADDR);
    chk("lane1 after rst", got, 8'h14);
    rd(THRESH_ADDR);
    chk("thresh after rst", got, THRESH_RST);
    rd(IRQ_STAT_ADDR);
    chk("irq stat after rst", got, ZERO_BYTE);
    chk("irq after rst", {7'h00, irq_o}, 8'h00);
    // Lane 0 code-group alignment won, then lost: loss event on its own bit
    rx_u.set_live(0, 0, 5'h01);
    rx_u.set_live(0, 0, 5'h00);
    repeat (3) @(posedge ref_clk_i);
    rd(IRQ_STAT_ADDR);
    chk("lane0 cgs loss", got, 8'h04);
  endtask
  initial begin
    srst_i = 1'h1;
    wr_en_i = 1'h0;
    rd_en_i = 1'h0;
    addr_i = '0;
    wr_data_i = '0;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    t_reset();
    t_live();
    t_thresh();
    t_irq();
    t_count();
    t_midreset();
    finish_test();
  end
endmodule : serdes_lane_link_status_bench
